/* File: src/gtl_regs.v */
// data and first event register set of the talker/listener, both ports
`timescale 1ns/1ps
`include "gtl_defines.vh"
// ****************************************************************
// register set
// ****************************************************************
// Notes on behaviour
// - per port three read and four write registers, direction picks which
// - second port sits at first port offsets plus 200 hex
// - received byte at 111; ready-for-data held false until byte taken
// - holdoff mode waits for finish-handshake command; byte rereadable
// - input byte bit 0 is data line 1, bit 7 is data line 8
// - outgoing byte latched apart from input byte at 111
// - written output byte starts source handshake once talker or controller is in source-generate
// - status at 113 clears on read; enables written at same offset
// - status independent of enables; interrupt needs set enable
// - events during a status read are held until read ends
// - command pass flag on undefined command with pass-through on
// - undefined primary flag set alike, cleared on defined or disable
// - pass-through stalls acceptor until valid code 0F or non-valid code 07 written
// - addressed commands ignored unless addressed
// - address pass flag on secondary with mode 3 and primary addressed
// - address pass stalls data-accepted until valid or non-valid command
// - trigger flag on entering trigger-active state
// - end flag on EOI or matching end-of-string while listening
// - clear flag on entering device-clear-active state
// - error flag on no listener, or write in source idle
// - data-out flag while talker-active and source-generate
// - data-in flag on accepted byte unless continuous mode
// - interrupt is OR of flags ANDed with enables
module gtl_regs #(
  parameter PORTS = 2,
  parameter FIFO_DEPTH = 4
) (
  input wire i_core_clk,
  input wire i_resetn,
  // host register port
  input wire [9:0] i_addr,
  input wire i_rd,
  input wire i_wr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  // bus state per port, from the bus function logic (same clock)
  input wire [PORTS-1:0] i_acds,
  input wire [PORTS-1:0] i_lacs,
  input wire [PORTS-1:0] i_tacs,
  input wire [PORTS-1:0] i_cacs,
  input wire [PORTS-1:0] i_sgns,
  input wire [PORTS-1:0] i_sdys,
  input wire [PORTS-1:0] i_sids,
  input wire [PORTS-1:0] i_sdys_to_sids,
  input wire [PORTS-1:0] i_tads,
  input wire [PORTS-1:0] i_lads,
  input wire [PORTS-1:0] i_tpas,
  input wire [PORTS-1:0] i_lpas,
  input wire [PORTS-1:0] i_dtas,
  input wire [PORTS-1:0] i_dcas,
  input wire [PORTS-1:0] i_ucg,
  input wire [PORTS-1:0] i_acg,
  input wire [PORTS-1:0] i_scg,
  input wire [PORTS-1:0] i_tag_lag,
  input wire [PORTS-1:0] i_defined,
  input wire [PORTS-1:0] i_eoi,
  input wire [PORTS-1:0] i_dac,
  input wire [PORTS-1:0] i_rfd_in,
  input wire [8*PORTS-1:0] i_dio,
  input wire [8*PORTS-1:0] i_string_end_reg,
  output reg [PORTS-1:0] o_rfd_hold,
  output reg [PORTS-1:0] o_dac_hold,
  output reg [PORTS-1:0] o_src_start,
  output reg [8*PORTS-1:0] o_dout,
  output reg [PORTS-1:0] o_irq
);
  // ****************************************************************
  // address decode
  // ****************************************************************
  function [1:0] gtl_sel;
    input [9:0] a;
    input [9:0] base;
    begin
      gtl_sel[0] = (a == base);
      gtl_sel[1] = (a == base + `GTL_PORT_STRIDE);
    end
  endfunction

  wire [1:0] sel_byte = gtl_sel(i_addr, `GTL_OFS_BYTE);
  wire [1:0] sel_stat = gtl_sel(i_addr, `GTL_OFS_STATUS1);
  wire [1:0] sel_aux = gtl_sel(i_addr, `GTL_OFS_AUXCMD);
  wire [1:0] sel_ctrl = gtl_sel(i_addr, `GTL_OFS_CTRL);

  reg [7:0] status [0:PORTS-1];
  reg [7:0] enable [0:PORTS-1];
  reg [7:0] in_byte [0:PORTS-1];
  reg [7:0] ctrl [0:PORTS-1];
  reg [7:0] pend [0:PORTS-1];
  reg [PORTS-1:0] acds_q;
  reg [PORTS-1:0] dtas_q;
  reg [PORTS-1:0] dcas_q;
  reg [PORTS-1:0] do_q;
  reg [PORTS-1:0] undef_primary;
  reg [PORTS-1:0] cmd_stall;
  reg [PORTS-1:0] byte_full;
  reg [PORTS-1:0] holding;

  // outgoing bytes queue through a FIFO_DEPTH-deep fifo each; a host write to a full fifo is lost
  wire [PORTS-1:0] f_in_ready;
  wire [PORTS-1:0] f_out_valid;
  wire [8*PORTS-1:0] f_out_data;
  wire [PORTS-1:0] f_push;
  wire [PORTS-1:0] f_pop;

  // ****************************************************************
  // per port logic
  // ****************************************************************
  genvar p;
  generate
    for (p = 0; p < PORTS; p = p + 1) begin : g_port
      wire rd_stat = i_rd && sel_stat[p];
      wire rd_byte = i_rd && sel_byte[p];
      wire wr_byte = i_wr && sel_byte[p];
      wire wr_aux = i_wr && sel_aux[p];
      wire pass_on = ctrl[p][`GTL_CTRL_PASS];
      wire acds_rise = i_acds[p] && !acds_q[p];
      wire addressed = i_tads[p] || i_lads[p];
      wire undef_cmd = (i_ucg[p] || (i_acg[p] && addressed)) &&
        !i_defined[p];
      wire fh_cmd = wr_aux && (i_wdata == `GTL_CMD_FINISH);
      wire talk_ok = i_tacs[p] || i_cacs[p];
      wire [7:0] ev;
      wire [7:0] next_status;
      assign ev[`GTL_BIT_CPT] = acds_rise && pass_on &&
        (undef_cmd || (undef_primary[p] && i_scg[p]));
      assign ev[`GTL_BIT_APT] = acds_rise && ctrl[p][`GTL_CTRL_ADDRESS_MODE_HIGH] &&
        ctrl[p][`GTL_CTRL_ADDRESS_MODE_LOW] && (i_tpas[p] || i_lpas[p]) &&
        i_scg[p];
      assign ev[`GTL_BIT_DET] = i_dtas[p] && !dtas_q[p];
      assign ev[`GTL_BIT_END] = acds_rise && i_lacs[p] && (i_eoi[p] ||
        (ctrl[p][`GTL_CTRL_EOS_ALLOW] &&
        i_dio[8*p+:8] == i_string_end_reg[8*p+:8]));
      assign ev[`GTL_BIT_DEC] = i_dcas[p] && !dcas_q[p];
      assign ev[`GTL_BIT_ERR] = (i_tacs[p] && i_sdys[p] && i_dac[p] &&
        i_rfd_in[p]) || (wr_byte && (i_sids[p] ||
        i_sdys_to_sids[p]));
      assign ev[`GTL_BIT_DO] = i_tacs[p] && i_sgns[p] && !do_q[p];
      assign ev[`GTL_BIT_DI] = acds_rise && i_lacs[p] &&
        !ctrl[p][`GTL_CTRL_CONT];
      // bits held back during a read are merged once it ends
      assign next_status = rd_stat ? 8'h00 : ((status[p] | pend[p] | ev) &
        ~{6'h00, (wr_byte || !(i_tacs[p] && i_sgns[p])),
        ((rd_byte || (fh_cmd && holding[p])) ? 1'b1 : 1'b0)});
      assign f_push[p] = wr_byte;
      assign f_pop[p] = f_out_valid[p] && talk_ok && !o_src_start[p] &&
        !i_sgns[p] ? 1'b0 : (f_out_valid[p] && talk_ok && i_sgns[p] &&
        !o_src_start[p]);

      gtl_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(2)
      ) u_out_fifo (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_in_valid(f_push[p]),
        .o_in_ready(f_in_ready[p]),
        .i_in_data(i_wdata),
        .o_out_valid(f_out_valid[p]),
        .i_out_ready(f_pop[p]),
        .o_out_data(f_out_data[8*p+:8])
      );

      always @(posedge i_core_clk) begin
        if (!i_resetn) begin
          status[p] <= `GTL_RESET_STATUS;
          enable[p] <= `GTL_RESET_ENABLE;
          pend[p] <= 8'h00;
          ctrl[p] <= 8'h00;
          in_byte[p] <= 8'h00;
          acds_q[p] <= 1'b0;
          dtas_q[p] <= 1'b0;
          dcas_q[p] <= 1'b0;
          do_q[p] <= 1'b0;
          undef_primary[p] <= 1'b0;
          cmd_stall[p] <= 1'b0;
          byte_full[p] <= 1'b0;
          holding[p] <= 1'b0;
          o_rfd_hold[p] <= 1'b0;
          o_dac_hold[p] <= 1'b0;
          o_src_start[p] <= 1'b0;
          o_dout[8*p+:8] <= 8'h00;
          o_irq[p] <= 1'b0;
        end else begin
          acds_q[p] <= i_acds[p];
          dtas_q[p] <= i_dtas[p];
          dcas_q[p] <= i_dcas[p];
          do_q[p] <= i_tacs[p] && i_sgns[p];
          status[p] <= next_status;
          pend[p] <= rd_stat ? ev : 8'h00;
          if (i_wr && sel_stat[p]) begin
            enable[p] <= i_wdata;
          end
          if (i_wr && sel_ctrl[p]) begin
            ctrl[p] <= i_wdata;
          end
          o_irq[p] <= |(next_status & (i_wr && sel_stat[p] ? i_wdata :
            enable[p]));
          if (!pass_on) begin
            undef_primary[p] <= 1'b0;
          end else if (acds_rise && undef_cmd) begin
            undef_primary[p] <= 1'b1;
          end else if (acds_rise && ((i_ucg[p] || i_acg[p]) &&
              i_defined[p] || i_tag_lag[p])) begin
            undef_primary[p] <= 1'b0;
          end
          if (ev[`GTL_BIT_CPT] || ev[`GTL_BIT_APT]) begin
            cmd_stall[p] <= 1'b1;
          end else if (wr_aux && (i_wdata == `GTL_CMD_VALID ||
              i_wdata == `GTL_CMD_NONVALID)) begin
            cmd_stall[p] <= 1'b0;
          end
          o_dac_hold[p] <= cmd_stall[p] || ev[`GTL_BIT_CPT] ||
            ev[`GTL_BIT_APT];
          if (acds_rise && i_lacs[p]) begin
            in_byte[p] <= i_dio[8*p+:8];
            byte_full[p] <= 1'b1;
            holding[p] <= ctrl[p][`GTL_CTRL_HOLDOFF];
          end else begin
            if (rd_byte && !holding[p]) begin
              byte_full[p] <= 1'b0;
            end
            if (fh_cmd) begin
              holding[p] <= 1'b0;
              byte_full[p] <= 1'b0;
            end
          end
          o_rfd_hold[p] <= byte_full[p] || (acds_rise && i_lacs[p]);
          o_src_start[p] <= f_pop[p];
          if (f_pop[p]) begin
            o_dout[8*p+:8] <= f_out_data[8*p+:8];
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // read mux
  // ****************************************************************
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      if (sel_byte[0]) begin
        o_rdata <= in_byte[0];
      end else if (sel_byte[1]) begin
        o_rdata <= in_byte[PORTS-1];
      end else if (sel_stat[0]) begin
        o_rdata <= status[0] | pend[0];
      end else if (sel_stat[1]) begin
        o_rdata <= status[PORTS-1] | pend[PORTS-1];
      end else if (sel_ctrl[0]) begin
        o_rdata <= ctrl[0];
      end else if (sel_ctrl[1]) begin
        o_rdata <= ctrl[PORTS-1];
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end
endmodule

/* File: include/gtl_defines.vh */
// register offsets, field positions and command codes of the talker/listener
`ifndef GTL_DEFINES_VH
`define GTL_DEFINES_VH
`define GTL_OFS_BYTE 10'h111
`define GTL_OFS_STATUS1 10'h113
`define GTL_OFS_AUXCMD 10'h105
`define GTL_OFS_CTRL 10'h107
`define GTL_PORT_STRIDE 10'h200
`define GTL_BIT_CPT 7
`define GTL_BIT_APT 6
`define GTL_BIT_DET 5
`define GTL_BIT_END 4
`define GTL_BIT_DEC 3
`define GTL_BIT_ERR 2
`define GTL_BIT_DO 1
`define GTL_BIT_DI 0
`define GTL_CMD_VALID 8'h0F
`define GTL_CMD_NONVALID 8'h07
`define GTL_CMD_FINISH 8'h03
`define GTL_RESET_STATUS 8'h00
`define GTL_RESET_ENABLE 8'h00
`define GTL_CTRL_PASS 0
`define GTL_CTRL_HOLDOFF 1
`define GTL_CTRL_CONT 2
`define GTL_CTRL_EOS_ALLOW 3
`define GTL_CTRL_ADDRESS_MODE_LOW 4
`define GTL_CTRL_ADDRESS_MODE_HIGH 5
`endif

/* File: src/gtl_fifo.v */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module gtl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign o_in_ready = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign o_out_data = mem[rptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always @(posedge i_core_clk) begin
    if (push) begin
      mem[wptr] <= i_in_data;
    end
  end
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

/* File: bench/gtl_regs_monitor.sv */
// assertion checker for the talker/listener register set
`timescale 1ns/1ps
module gtl_regs_monitor #(parameter PORTS = 2) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire [9:0] i_addr,
  input wire i_rd,
  input wire i_wr,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  input wire [PORTS-1:0] i_acds,
  input wire [PORTS-1:0] i_lacs,
  input wire [PORTS-1:0] i_tacs,
  input wire [PORTS-1:0] i_cacs,
  input wire [PORTS-1:0] o_rfd_hold,
  input wire [PORTS-1:0] o_dac_hold,
  input wire [PORTS-1:0] o_src_start,
  input wire [8*PORTS-1:0] o_dout,
  input wire [PORTS-1:0] o_irq
);
  // **
  // helpers
  // **
  // release may lag the host access by one register stage
  wire take_a = i_rd && i_addr == 10'h111 || i_wr && i_addr == 10'h105;
  wire aux_ok = i_wr && i_addr == 10'h105 && (i_wdata == 8'h0F
    || i_wdata == 8'h07);
  wire talk_a = i_tacs[0] || i_cacs[0];
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // **
  // properties
  // **
  property p_reset;
    disable iff (1'h0) !i_resetn |=> o_irq == 0 && o_rfd_hold == 0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
  property p_rfd_set;
    $rose(i_acds[0]) && i_lacs[0] |-> ##[1:3] o_rfd_hold[0];
  endproperty
  a_rfd_set: assert property (p_rfd_set)
    else $error("ready-for-data not held after byte");
  property p_rfd_rel;
    $fell(o_rfd_hold[0]) |-> $past(take_a) || $past(take_a, 2);
  endproperty
  a_rfd_rel: assert property (p_rfd_rel)
    else $error("ready-for-data released without cause");
  property p_dac_rel;
    $fell(o_dac_hold[0]) |-> $past(aux_ok) || $past(aux_ok, 2);
  endproperty
  a_dac_rel: assert property (p_dac_rel)
    else $error("data-accepted released without command");
  property p_src;
    o_src_start[0] |-> $past(talk_a) || $past(talk_a, 2);
  endproperty
  a_src: assert property (p_src)
    else $error("source start while not talker");
  property p_dout;
    $changed(o_dout[7:0]) |-> o_src_start[0];
  endproperty
  a_dout: assert property (p_dout)
    else $error("outgoing byte changed outside a start");
  property p_rdata;
    $changed(o_rdata) |-> $past(i_rd);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data changed without a read");
  property p_irq_off;
    i_wr && i_addr == 10'h113 && i_wdata == 8'h00 |-> ##3 !o_irq[0];
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt with all enables clear");
endmodule

/* File: bench/gtl_partner.sv */
// far-side talker and listener model on the instrument bus
`timescale 1ns/1ps
module gtl_partner (
  input wire i_core_clk,
  input wire i_resetn,
  input wire [1:0] i_put,
  input wire [7:0] i_byte,
  input wire i_end,
  input wire i_absent,
  output reg [15:0] o_dio,
  output reg [1:0] o_eoi,
  output reg [1:0] o_dac,
  output reg [1:0] o_rfd
);
  // released lines toggle so a stale byte never looks valid
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_dio <= 16'h5A5A;
      o_eoi <= 2'h0;
      o_dac <= 2'h0;
      o_rfd <= 2'h0;
    end else begin
      o_dio[7:0] <= i_put[0] ? i_byte : ~o_dio[7:0];
      o_dio[15:8] <= i_put[1] ? i_byte : ~o_dio[15:8];
      o_eoi <= i_put & {2{i_end}};
      // no listener: both handshake lines float true
      o_dac <= {2{i_absent}};
      o_rfd <= {2{i_absent}};
    end
  end
endmodule

/* File: bench/gtl_regs_bench.sv */
// self-checking bench for the talker/listener register set
`timescale 1ns/1ps
module gtl_regs_bench;
  logic i_core_clk = 1'h0, i_resetn = 1'h0, i_rd = 1'h0, i_wr = 1'h0;
  logic [9:0] i_addr = 10'h000;
  logic [7:0] i_wdata = 8'h00, pb = 8'h00;
  logic pe = 1'h0, absent = 1'h0;
  logic [1:0] put = 2'h0, i_acds = 2'h0, i_lacs = 2'h0, i_tacs = 2'h0;
  logic [1:0] i_cacs = 2'h0, i_sgns = 2'h0, i_sdys = 2'h0, i_tads = 2'h0;
  logic [1:0] i_tpas = 2'h0, i_dtas = 2'h0, i_dcas = 2'h0, i_ucg = 2'h0;
  logic [1:0] i_acg = 2'h0, i_scg = 2'h0, i_defined = 2'h0;
  logic [1:0] i_sids = 2'h0, i_lads = 2'h0;
  logic [15:0] i_string_end_reg = 16'h0000;
  logic [16:0] sd = 17'h16502;
  wire [1:0] i_eoi, i_dac, i_rfd_in, o_rfd_hold, o_dac_hold, o_src_start;
  wire [1:0] o_irq;
  wire [15:0] i_dio, o_dout;
  wire [7:0] o_rdata;
  int err_total = 0, total_checks = 0, cyc_n = 0, k;
  gtl_regs #(.PORTS(2), .FIFO_DEPTH(4)) i_gtl_regs (
    .i_core_clk, .i_resetn, .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata,
    .i_acds, .i_lacs, .i_tacs, .i_cacs, .i_sgns, .i_sdys, .i_sids,
    .i_sdys_to_sids(2'h0), .i_tads, .i_lads, .i_tpas, .i_lpas(2'h0),
    .i_dtas, .i_dcas, .i_ucg, .i_acg, .i_scg, .i_tag_lag(2'h0), .i_defined,
    .i_eoi, .i_dac, .i_rfd_in, .i_dio, .i_string_end_reg, .o_rfd_hold,
    .o_dac_hold, .o_src_start, .o_dout, .o_irq);
  gtl_partner i_gtl_partner (.i_core_clk, .i_resetn, .i_put(put),
    .i_byte(pb), .i_end(pe), .i_absent(absent), .o_dio(i_dio),
    .o_eoi(i_eoi), .o_dac(i_dac), .o_rfd(i_rfd_in));
  // **
  // helpers
  // **
  function logic [16:0] nx(input logic [16:0] s);
    nx = {s[15:0], s[16] ^ s[13]};
  endfunction
  function logic [7:0] stat(input logic di, input logic en);
    stat = {3'h0, en, 3'h0, di};
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task chkb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task wrr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_core_clk);
    i_wr <= 1'h0;
  endtask
  task rdr(input logic [9:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_core_clk);
    i_rd <= 1'h0;
    #1;
    chk(o_rdata, e);
  endtask
  task acc(input int p);
    @(posedge i_core_clk);
    i_acds[p] <= 1'h1;
    repeat (3) @(posedge i_core_clk);
    i_acds[p] <= 1'h0;
  endtask
  task lsn(input int p, input logic [7:0] v, input logic e);
    @(posedge i_core_clk);
    i_lacs[p] <= 1'h1;
    put[p] <= 1'h1;
    pb <= v;
    pe <= e;
    acc(p);
    put[p] <= 1'h0;
    i_lacs[p] <= 1'h0;
  endtask
  // a start pulse stands one cycle, so poll every cycle
  task grab(input logic [7:0] e);
    cyc(1);
    for (int n = 0; n < 40 && o_src_start[0] !== 1'h1; n++)
      cyc(1);
    chkb(o_src_start[0], 1'h1);
    chk(o_dout[7:0], e);
  endtask
  task close_out;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // **
  // clock and timeout
  // **
  initial begin
    forever #10 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_total++;
      close_out;
    end
  end
  // **
  // scenarios
  // **
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_resetn <= 1'h1;
    rdr(10'h113, 8'h00);
    chkb(o_irq[0], 1'h0);
    for (k = 0; k < 4; k++) begin
      sd = nx(sd);
      lsn(0, sd[7:0], k[0]);
      cyc(1);
      chkb(o_rfd_hold[0], 1'h1);
      rdr(10'h111, sd[7:0]);
      cyc(2);
      chkb(o_rfd_hold[0], 1'h0);
      rdr(10'h113, stat(1'h0, k[0]));
    end
    wrr(10'h113, 8'h01);
    lsn(0, 8'h3C, 1'h0);
    cyc(2);
    chkb(o_irq[0], 1'h1);
    rdr(10'h113, 8'h01);
    cyc(2);
    chkb(o_irq[0], 1'h0);
    wrr(10'h113, 8'h00);
    rdr(10'h111, 8'h3C);
    wrr(10'h107, 8'h02);
    lsn(0, 8'h96, 1'h0);
    rdr(10'h111, 8'h96);
    rdr(10'h111, 8'h96);
    chkb(o_rfd_hold[0], 1'h1);
    wrr(10'h105, 8'h03);
    cyc(2);
    chkb(o_rfd_hold[0], 1'h0);
    wrr(10'h107, 8'h08);
    i_string_end_reg <= 16'h0055;
    lsn(0, 8'h55, 1'h0);
    rdr(10'h113, 8'h11);
    rdr(10'h111, 8'h55);
    wrr(10'h107, 8'h00);
    lsn(1, 8'hC3, 1'h0);
    rdr(10'h311, 8'hC3);
    wrr(10'h0F3, 8'hFF);
    rdr(10'h0F3, 8'h00);
    @(posedge i_core_clk) i_cacs <= 2'h1;
    for (k = 0; k < 5; k++)
      wrr(10'h111, 8'hA0 + k[7:0]);
    rdr(10'h111, 8'h55);
    @(posedge i_core_clk) i_sgns <= 2'h1;
    for (k = 0; k < 4; k++)
      grab(8'hA0 + k[7:0]);
    @(posedge i_core_clk) i_cacs <= 2'h0;
    i_tacs <= 2'h1;
    cyc(2);
    rdr(10'h113, 8'h02);
    sd = nx(sd);
    wrr(10'h111, sd[7:0]);
    grab(sd[7:0]);
    @(posedge i_core_clk) i_sgns <= 2'h0;
    i_sdys <= 2'h1;
    absent <= 1'h1;
    cyc(4);
    // drop the no-listener condition first, else it sets again after the read
    @(posedge i_core_clk) i_sdys <= 2'h0;
    absent <= 1'h0;
    rdr(10'h113, 8'h04);
    i_sids <= 2'h1;
    wrr(10'h111, 8'h5A);
    i_sids <= 2'h0;
    rdr(10'h113, 8'h04);
    i_tacs <= 2'h0;
    i_dtas <= 2'h1;
    i_dcas <= 2'h1;
    acc(0);
    i_dtas <= 2'h0;
    i_dcas <= 2'h0;
    rdr(10'h113, 8'h28);
    wrr(10'h107, 8'h01);
    i_ucg <= 2'h1;
    i_defined <= 2'h1;
    acc(0);
    rdr(10'h113, 8'h00);
    @(posedge i_core_clk) i_defined <= 2'h0;
    acc(0);
    cyc(1);
    chkb(o_dac_hold[0], 1'h1);
    rdr(10'h113, 8'h80);
    wrr(10'h105, 8'h0F);
    cyc(2);
    chkb(o_dac_hold[0], 1'h0);
    @(posedge i_core_clk) i_ucg <= 2'h0;
    i_acg <= 2'h1;
    acc(0);
    rdr(10'h113, 8'h00);
    @(posedge i_core_clk) i_tads <= 2'h1;
    acc(0);
    rdr(10'h113, 8'h80);
    wrr(10'h105, 8'h0F);
    i_acg <= 2'h0;
    i_tads <= 2'h0;
    i_tpas <= 2'h1;
    i_scg <= 2'h1;
    wrr(10'h107, 8'h30);
    acc(0);
    cyc(1);
    chkb(o_dac_hold[0], 1'h1);
    rdr(10'h113, 8'h40);
    wrr(10'h105, 8'h07);
    cyc(2);
    chkb(o_dac_hold[0], 1'h0);
    close_out;
  end
endmodule
bind gtl_regs gtl_regs_monitor #(.PORTS(PORTS)) i_gtl_regs_monitor (
  .i_core_clk, .i_resetn, .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata,
  .i_acds, .i_lacs, .i_tacs, .i_cacs, .o_rfd_hold, .o_dac_hold,
  .o_src_start, .o_dout, .o_irq);
